// *** hdl/fra_pkg.sv ***
// Operation
// (R1) Wait-state code sets flash read wait states.
// (R2) Software picks code from voltage/frequency table.
// (R3) Software keeps wait states above minimum.
// (R4) Prefetch buffer holds next 128-bit phrase.
// (R5) Cache is 64 bytes, four 16-byte ways.
// (R6) Ways numbered 0-3; LRU replacement per set.
// (R7) Software selects algorithm, locks, invalidates ways.
// (R8) Software invalidates copies after flash reprogramming.
// (R9) Buffer hit moves to cache, fetches next.
// (R10) Cache off: speculation still advances.
// (R11) Speculation reads next phrase after each read.
// (R12) Prefetch invalidation here; enables in control word.
// (R13) Speculation disable bits reset cleared.
// (R14) Multibit data block resets set, blocks speculation.
// (R15) Startup software clears multibit data block.
// (R16) Cache enabled from reset via control word.
// (R17) Cache hit inserts no flash wait states.
// (R18) Software keeps cache on with speculation.
// (R19) Wait-state field resets to three.
// (R20) Miss fills LRU unlocked way; none if all locked.
package fra_pkg;

  localparam int ADDR_W   = 21;
  localparam int PHR_W    = 17;
  localparam int PHR_LSB  = 4;
  localparam int WORD_LSB = 2;
  localparam int WAYS     = 4;
  localparam int WAY_W    = 2;
  localparam int LINE_W   = 128;
  localparam int WORD_W   = 32;
  localparam int SEL_W    = 2;
  localparam int WAIT_W   = 4;
  localparam int NVM_W    = 5;
  localparam int REG_A_W  = 8;

  localparam logic [WAIT_W-1:0] WAIT_RST = 4'h3;
  localparam logic [WAIT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [PHR_W-1:0]  PHR_ONE  = 17'h00001;

  localparam logic [REG_A_W-1:0] OFF_FLASH_CTRL = 8'h00;
  localparam logic [REG_A_W-1:0] OFF_NV_WORD    = 8'h04;
  localparam logic [REG_A_W-1:0] OFF_ACCEL_CTRL = 8'h08;
  localparam logic [REG_A_W-1:0] OFF_STATUS     = 8'h0C;

  localparam int NVM_DSPEC_OFF = 0;
  localparam int NVM_ISPEC_OFF = 1;
  localparam int NVM_MBE_DATA  = 2;
  localparam int NVM_MBE_INST  = 3;
  localparam int NVM_CACHE_OFF = 4;
  localparam logic [NVM_W-1:0] NVM_RST = 5'h04;

  localparam int ACC_LOCK_LSB = 0;
  localparam int ACC_INV_LSB  = 4;
  localparam int ACC_PF_INV   = 8;
  localparam int ACC_ALG      = 9;

  localparam int STA_VLD_LSB = 0;
  localparam int STA_PF_VLD  = 4;
  localparam int STA_BUSY    = 5;

  localparam logic ALG_LRU = 1'b0;

  typedef enum logic [1:0] {FRA_IDLE, FRA_HIT, FRA_FLASH, FRA_PREF} fra_state_e;

  // Picks one 32-bit word out of a 128-bit phrase.
  function automatic logic [WORD_W-1:0] word_sel(input logic [LINE_W-1:0] line,
                                                 input logic [SEL_W-1:0]  sel);
    word_sel = line[sel*WORD_W +: WORD_W];
  endfunction : word_sel

endpackage : fra_pkg

// *** hdl/fra_line_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module fra_line_mem (
  input  wire logic                          mclk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          we_i,
  input  wire logic [fra_pkg::WAY_W-1:0]     widx_i,
  input  wire logic [fra_pkg::LINE_W-1:0]    wdata_i,
  input  wire logic [fra_pkg::WAY_W-1:0]     ridx_i,
  input  wire logic [fra_pkg::SEL_W-1:0]     rword_i,
  output logic      [fra_pkg::WORD_W-1:0]    rdata_o
);

  logic [fra_pkg::LINE_W-1:0] mem [fra_pkg::WAYS];
  logic [fra_pkg::WORD_W-1:0] rdata_ff;
  logic [fra_pkg::WORD_W-1:0] nxt_rdata;

  // The word leaves through a register so the caller sees a clean flop.
  always_comb
  begin
    nxt_rdata = fra_pkg::word_sel(mem[ridx_i], rword_i);
  end

  // Line storage carries no reset; valid bits elsewhere guard it.
  always_ff @(posedge mclk_i)
  begin
    if (we_i)
    begin
      mem[widx_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff <= '0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;

endmodule : fra_line_mem
`default_nettype wire

// *** hdl/fra_repl.sv ***
`timescale 1ns/1ps
`default_nettype none
module fra_repl (
  input  wire logic                          mclk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          touch_i,
  input  wire logic [fra_pkg::WAY_W-1:0]     touch_way_i,
  input  wire logic                          fill_i,
  input  wire logic [fra_pkg::WAYS-1:0]      lock_i,
  input  wire logic [fra_pkg::WAYS-1:0]      valid_i,
  input  wire logic                          alg_i,
  output logic      [fra_pkg::WAY_W-1:0]     victim_o,
  output logic                               victim_ok_o
);

  logic [fra_pkg::WAY_W-1:0] age_ff     [fra_pkg::WAYS];
  logic [fra_pkg::WAY_W-1:0] nxt_age    [fra_pkg::WAYS];
  logic [fra_pkg::WAY_W-1:0] rr_ff;
  logic [fra_pkg::WAY_W-1:0] nxt_rr;
  logic [fra_pkg::WAY_W-1:0] best_age;
  logic [fra_pkg::WAY_W-1:0] cand;
  logic                      found_inv;

  // Invalid unlocked ways go first, then the oldest or the round-robin pick.
  always_comb
  begin
    victim_o    = '0;
    victim_ok_o = 1'b0;
    found_inv   = 1'b0;
    best_age    = '0;
    cand        = '0;
    for (int w = 0; w < fra_pkg::WAYS; w++)
    begin
      if (!lock_i[w] && !valid_i[w] && !found_inv)
      begin
        found_inv   = 1'b1;
        victim_o    = w[fra_pkg::WAY_W-1:0];
        victim_ok_o = 1'b1;
      end
    end
    for (int w = 0; w < fra_pkg::WAYS; w++)
    begin
      cand = rr_ff + w[fra_pkg::WAY_W-1:0];
      if (!found_inv && alg_i == fra_pkg::ALG_LRU && !lock_i[w]
          && (!victim_ok_o || age_ff[w] > best_age))
      begin
        victim_o    = w[fra_pkg::WAY_W-1:0]; // R6
        best_age    = age_ff[w];
        victim_ok_o = 1'b1; // R20
      end
      else if (!found_inv && alg_i != fra_pkg::ALG_LRU && !lock_i[cand] && !victim_ok_o)
      begin
        victim_o    = cand; // R7
        victim_ok_o = 1'b1;
      end
    end
  end

  // A touched way becomes youngest; younger ones age by one.
  always_comb
  begin
    nxt_rr = rr_ff;
    for (int w = 0; w < fra_pkg::WAYS; w++)
    begin
      nxt_age[w] = age_ff[w];
      if (touch_i && w[fra_pkg::WAY_W-1:0] == touch_way_i)
      begin
        nxt_age[w] = '0; // R6
      end
      else if (touch_i && age_ff[w] < age_ff[touch_way_i])
      begin
        nxt_age[w] = age_ff[w] + 2'h1;
      end
    end
    if (fill_i)
    begin
      nxt_rr = touch_way_i + 2'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      age_ff <= '{2'h0, 2'h1, 2'h2, 2'h3};
      rr_ff  <= '0;
    end
    else
    begin
      age_ff <= nxt_age;
      rr_ff  <= nxt_rr;
    end
  end

endmodule : fra_repl
`default_nettype wire

// *** hdl/fra_flash_read_accel.sv ***
`timescale 1ns/1ps
`default_nettype none
module fra_flash_read_accel (
  input  wire logic                           mclk_i,
  input  wire logic                           rst_n_i,
  input  wire logic [fra_pkg::REG_A_W-1:0]    reg_addr_i,
  input  wire logic [fra_pkg::WORD_W-1:0]     reg_wdata_i,
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  output logic      [fra_pkg::WORD_W-1:0]     reg_rdata_o,
  input  wire logic                           req_i,
  input  wire logic                           req_instr_i,
  input  wire logic [fra_pkg::ADDR_W-1:0]     req_addr_i,
  output logic                                ready_o,
  output logic                                ack_o,
  output logic      [fra_pkg::WORD_W-1:0]     rdata_o,
  output logic                                fl_rd_o,
  output logic      [fra_pkg::PHR_W-1:0]      fl_addr_o,
  input  wire logic [fra_pkg::LINE_W-1:0]     fl_rdata_i
);

  // Software-visible state.
  logic [fra_pkg::WAIT_W-1:0] wait_ff;
  logic [fra_pkg::WAIT_W-1:0] nxt_wait;
  logic [fra_pkg::NVM_W-1:0]  nvm_ff;
  logic [fra_pkg::NVM_W-1:0]  nxt_nvm;
  logic [fra_pkg::WAYS-1:0]   lock_ff;
  logic [fra_pkg::WAYS-1:0]   nxt_lock;
  logic                       alg_ff;
  logic                       nxt_alg;
  logic [fra_pkg::WORD_W-1:0] reg_rdata_ff;
  logic [fra_pkg::WORD_W-1:0] nxt_reg_rdata;
  logic [fra_pkg::WAYS-1:0]   inv_ways;
  logic                       pf_inv;
  logic                       cache_en;

  // Engine state.
  fra_pkg::fra_state_e        state_ff;
  fra_pkg::fra_state_e        nxt_state;
  logic [fra_pkg::WAIT_W-1:0] cnt_ff;
  logic [fra_pkg::WAIT_W-1:0] nxt_cnt;
  logic [fra_pkg::PHR_W-1:0]  tag_ff  [fra_pkg::WAYS];
  logic [fra_pkg::PHR_W-1:0]  nxt_tag [fra_pkg::WAYS];
  logic [fra_pkg::WAYS-1:0]   vld_ff;
  logic [fra_pkg::WAYS-1:0]   nxt_vld;
  logic [fra_pkg::PHR_W-1:0]  pf_tag_ff;
  logic [fra_pkg::PHR_W-1:0]  nxt_pf_tag;
  logic [fra_pkg::LINE_W-1:0] pf_data_ff;
  logic [fra_pkg::LINE_W-1:0] nxt_pf_data;
  logic                       pf_vld_ff;
  logic                       nxt_pf_vld;
  logic                       pf_drop_ff;
  logic                       nxt_pf_drop;
  logic [fra_pkg::PHR_W-1:0]  phr_ff;
  logic [fra_pkg::PHR_W-1:0]  nxt_phr;
  logic [fra_pkg::SEL_W-1:0]  word_ff;
  logic [fra_pkg::SEL_W-1:0]  nxt_word;
  logic                       spec_ff;
  logic                       nxt_spec;
  logic                       ready_ff;
  logic                       nxt_ready;
  logic                       ack_ff;
  logic                       nxt_ack;
  logic [fra_pkg::WORD_W-1:0] rdata_ff;
  logic [fra_pkg::WORD_W-1:0] nxt_rdata;
  logic                       fl_rd_ff;
  logic                       nxt_fl_rd;
  logic [fra_pkg::PHR_W-1:0]  fl_addr_ff;
  logic [fra_pkg::PHR_W-1:0]  nxt_fl_addr;

  // Lookup and side signals.
  logic [fra_pkg::PHR_W-1:0]  req_phr;
  logic [fra_pkg::SEL_W-1:0]  req_word;
  logic [fra_pkg::WAYS-1:0]   hit_vec;
  logic [fra_pkg::WAY_W-1:0]  hit_idx;
  logic                       pf_hit;
  logic                       req_spec;
  logic                       mem_we;
  logic [fra_pkg::WAY_W-1:0]  mem_widx;
  logic [fra_pkg::LINE_W-1:0] mem_wdata;
  logic [fra_pkg::WAY_W-1:0]  mem_ridx;
  logic [fra_pkg::WORD_W-1:0] mem_rdata;
  logic                       touch;
  logic [fra_pkg::WAY_W-1:0]  touch_way;
  logic                       fill;
  logic [fra_pkg::WAY_W-1:0]  victim;
  logic                       victim_ok;

  // The multibit data block overrides both clear disable bits.
  function automatic logic spec_allowed(input logic [fra_pkg::NVM_W-1:0] nvm,
                                        input logic                      instr);
    logic path_off;
    path_off = instr ? nvm[fra_pkg::NVM_ISPEC_OFF] | nvm[fra_pkg::NVM_MBE_INST]
                     : nvm[fra_pkg::NVM_DSPEC_OFF];
    spec_allowed = !path_off && !nvm[fra_pkg::NVM_MBE_DATA]; // R14
  endfunction : spec_allowed

  assign req_phr  = req_addr_i[fra_pkg::ADDR_W-1:fra_pkg::PHR_LSB];
  assign req_word = req_addr_i[fra_pkg::PHR_LSB-1:fra_pkg::WORD_LSB];
  assign cache_en = !nvm_ff[fra_pkg::NVM_CACHE_OFF]; // R16
  assign req_spec = spec_allowed(nvm_ff, req_instr_i);
  assign pf_hit   = pf_vld_ff && (pf_tag_ff == req_phr);
  assign inv_ways = (reg_wr_i && reg_addr_i == fra_pkg::OFF_ACCEL_CTRL)
                    ? reg_wdata_i[fra_pkg::ACC_INV_LSB +: fra_pkg::WAYS] : '0; // R7
  assign pf_inv   = reg_wr_i && reg_addr_i == fra_pkg::OFF_ACCEL_CTRL
                    && reg_wdata_i[fra_pkg::ACC_PF_INV]; // R12

  // Tag compare per way; a disabled cache never hits.
  genvar gw;
  generate
    for (gw = 0; gw < fra_pkg::WAYS; gw++)
    begin : g_hit
      assign hit_vec[gw] = cache_en && vld_ff[gw] && (tag_ff[gw] == req_phr);
    end
  endgenerate

  always_comb
  begin
    hit_idx = '0;
    for (int w = 0; w < fra_pkg::WAYS; w++)
    begin
      if (hit_vec[w])
      begin
        hit_idx = w[fra_pkg::WAY_W-1:0];
      end
    end
  end

  // Register writes and the registered read answer.
  always_comb
  begin
    nxt_wait      = wait_ff;
    nxt_nvm       = nvm_ff;
    nxt_lock      = lock_ff;
    nxt_alg       = alg_ff;
    nxt_reg_rdata = '0;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        fra_pkg::OFF_FLASH_CTRL: nxt_wait = reg_wdata_i[fra_pkg::WAIT_W-1:0]; // R1
        fra_pkg::OFF_NV_WORD:    nxt_nvm  = reg_wdata_i[fra_pkg::NVM_W-1:0]; // R12
        fra_pkg::OFF_ACCEL_CTRL:
        begin
          nxt_lock = reg_wdata_i[fra_pkg::ACC_LOCK_LSB +: fra_pkg::WAYS]; // R7
          nxt_alg  = reg_wdata_i[fra_pkg::ACC_ALG];
        end
        default: nxt_wait = wait_ff;
      endcase
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        fra_pkg::OFF_FLASH_CTRL: nxt_reg_rdata[fra_pkg::WAIT_W-1:0] = wait_ff;
        fra_pkg::OFF_NV_WORD:    nxt_reg_rdata[fra_pkg::NVM_W-1:0]  = nvm_ff;
        fra_pkg::OFF_ACCEL_CTRL:
        begin
          nxt_reg_rdata[fra_pkg::ACC_LOCK_LSB +: fra_pkg::WAYS] = lock_ff;
          nxt_reg_rdata[fra_pkg::ACC_ALG] = alg_ff;
        end
        fra_pkg::OFF_STATUS:
        begin
          nxt_reg_rdata[fra_pkg::STA_VLD_LSB +: fra_pkg::WAYS] = vld_ff;
          nxt_reg_rdata[fra_pkg::STA_PF_VLD] = pf_vld_ff;
          nxt_reg_rdata[fra_pkg::STA_BUSY]   = (state_ff != fra_pkg::FRA_IDLE);
        end
        default: nxt_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wait_ff      <= fra_pkg::WAIT_RST; // R19
      nvm_ff       <= fra_pkg::NVM_RST; // R13 R14 R16
      lock_ff      <= '0;
      alg_ff       <= fra_pkg::ALG_LRU;
      reg_rdata_ff <= '0;
    end
    else
    begin
      wait_ff      <= nxt_wait;
      nvm_ff       <= nxt_nvm;
      lock_ff      <= nxt_lock;
      alg_ff       <= nxt_alg;
      reg_rdata_ff <= nxt_reg_rdata;
    end
  end

  // Access engine: cache lookup, buffer hit, demand read, speculative read.
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_tag     = tag_ff;
    nxt_phr     = phr_ff;
    nxt_word    = word_ff;
    nxt_spec    = spec_ff;
    nxt_pf_tag  = pf_tag_ff;
    nxt_pf_data = pf_data_ff;
    nxt_pf_vld  = pf_vld_ff && !pf_inv;
    nxt_pf_drop = pf_drop_ff || pf_inv;
    nxt_ready   = ready_ff;
    nxt_ack     = 1'b0;
    nxt_rdata   = rdata_ff;
    nxt_fl_rd   = fl_rd_ff;
    nxt_fl_addr = fl_addr_ff;
    nxt_vld     = vld_ff & ~inv_ways;
    mem_we      = 1'b0;
    mem_widx    = victim;
    mem_wdata   = fl_rdata_i;
    mem_ridx    = hit_idx;
    touch       = 1'b0;
    touch_way   = hit_idx;
    fill        = 1'b0;
    case (state_ff)
      fra_pkg::FRA_IDLE:
      begin
        if (req_i && ready_ff)
        begin
          nxt_ready = 1'b0;
          nxt_phr   = req_phr;
          nxt_word  = req_word;
          nxt_spec  = req_spec;
          if (|hit_vec)
          begin
            // The line was fetched earlier, so no flash wait is paid.
            touch     = 1'b1; // R17
            nxt_state = fra_pkg::FRA_HIT;
          end
          else if (pf_hit)
          begin
            nxt_ack    = 1'b1;
            nxt_rdata  = fra_pkg::word_sel(pf_data_ff, req_word);
            nxt_pf_vld = 1'b0; // R10
            if (cache_en && victim_ok)
            begin
              mem_we            = 1'b1; // R9
              mem_wdata         = pf_data_ff;
              nxt_tag[victim]   = req_phr;
              nxt_vld[victim]   = 1'b1;
              touch             = 1'b1;
              touch_way         = victim;
              fill              = 1'b1;
            end
            if (req_spec)
            begin
              nxt_fl_rd   = 1'b1; // R9
              nxt_fl_addr = req_phr + fra_pkg::PHR_ONE;
              nxt_cnt     = '0;
              nxt_pf_drop = 1'b0;
              nxt_state   = fra_pkg::FRA_PREF;
            end
            else
            begin
              nxt_ready = 1'b1;
            end
          end
          else
          begin
            nxt_fl_rd   = 1'b1;
            nxt_fl_addr = req_phr;
            nxt_cnt     = '0;
            nxt_state   = fra_pkg::FRA_FLASH;
          end
        end
      end
      fra_pkg::FRA_HIT:
      begin
        nxt_ack   = 1'b1;
        nxt_rdata = mem_rdata;
        nxt_ready = 1'b1;
        nxt_state = fra_pkg::FRA_IDLE;
      end
      fra_pkg::FRA_FLASH:
      begin
        nxt_cnt = cnt_ff + fra_pkg::CNT_ONE;
        if (cnt_ff >= wait_ff) // R1
        begin
          nxt_ack   = 1'b1;
          nxt_rdata = fra_pkg::word_sel(fl_rdata_i, word_ff);
          if (cache_en && victim_ok) // R20
          begin
            mem_we          = 1'b1; // R5
            nxt_tag[victim] = phr_ff;
            nxt_vld[victim] = 1'b1;
            touch           = 1'b1;
            touch_way       = victim;
            fill            = 1'b1;
          end
          if (spec_ff)
          begin
            nxt_fl_addr = phr_ff + fra_pkg::PHR_ONE; // R11
            nxt_cnt     = '0;
            nxt_pf_drop = 1'b0;
            nxt_state   = fra_pkg::FRA_PREF;
          end
          else
          begin
            nxt_fl_rd = 1'b0;
            nxt_ready = 1'b1;
            nxt_state = fra_pkg::FRA_IDLE;
          end
        end
      end
      fra_pkg::FRA_PREF:
      begin
        nxt_cnt = cnt_ff + fra_pkg::CNT_ONE;
        if (cnt_ff >= wait_ff) // R1
        begin
          // An invalidate during the fetch discards the landing phrase.
          nxt_pf_data = fl_rdata_i; // R4
          nxt_pf_tag  = fl_addr_ff;
          nxt_pf_vld  = !pf_drop_ff && !pf_inv;
          nxt_fl_rd   = 1'b0;
          nxt_ready   = 1'b1;
          nxt_state   = fra_pkg::FRA_IDLE;
        end
      end
      default: nxt_state = fra_pkg::FRA_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff   <= fra_pkg::FRA_IDLE;
      cnt_ff     <= '0;
      tag_ff     <= '{default: '0};
      vld_ff     <= '0;
      pf_tag_ff  <= '0;
      pf_data_ff <= '0;
      pf_vld_ff  <= 1'b0;
      pf_drop_ff <= 1'b0;
      phr_ff     <= '0;
      word_ff    <= '0;
      spec_ff    <= 1'b0;
      ready_ff   <= 1'b1;
      ack_ff     <= 1'b0;
      rdata_ff   <= '0;
      fl_rd_ff   <= 1'b0;
      fl_addr_ff <= '0;
    end
    else
    begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      tag_ff     <= nxt_tag;
      vld_ff     <= nxt_vld;
      pf_tag_ff  <= nxt_pf_tag;
      pf_data_ff <= nxt_pf_data;
      pf_vld_ff  <= nxt_pf_vld;
      pf_drop_ff <= nxt_pf_drop;
      phr_ff     <= nxt_phr;
      word_ff    <= nxt_word;
      spec_ff    <= nxt_spec;
      ready_ff   <= nxt_ready;
      ack_ff     <= nxt_ack;
      rdata_ff   <= nxt_rdata;
      fl_rd_ff   <= nxt_fl_rd;
      fl_addr_ff <= nxt_fl_addr;
    end
  end

  // Line data for the four ways.
  fra_line_mem u_mem (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .we_i    (mem_we),
    .widx_i  (mem_widx),
    .wdata_i (mem_wdata),
    .ridx_i  (mem_ridx),
    .rword_i (req_word),
    .rdata_o (mem_rdata)
  );

  // Victim choice and recency tracking.
  fra_repl u_repl (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .touch_i     (touch),
    .touch_way_i (touch_way),
    .fill_i      (fill),
    .lock_i      (lock_ff),
    .valid_i     (vld_ff),
    .alg_i       (alg_ff),
    .victim_o    (victim),
    .victim_ok_o (victim_ok)
  );

  assign reg_rdata_o = reg_rdata_ff;
  assign ready_o     = ready_ff;
  assign ack_o       = ack_ff;
  assign rdata_o     = rdata_ff;
  assign fl_rd_o     = fl_rd_ff;
  assign fl_addr_o   = fl_addr_ff;

endmodule : fra_flash_read_accel
`default_nettype wire

// *** testbench/fra_flash_read_accel_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module fra_flash_read_accel_checker (
  input wire logic         mclk_i,
  input wire logic         rst_n_i,
  input wire logic [7:0]   reg_addr_i,
  input wire logic [31:0]  reg_wdata_i,
  input wire logic         reg_wr_i,
  input wire logic         reg_rd_i,
  input wire logic [31:0]  reg_rdata_o,
  input wire logic         req_i,
  input wire logic         req_instr_i,
  input wire logic [20:0]  req_addr_i,
  input wire logic         ready_o,
  input wire logic         ack_o,
  input wire logic [31:0]  rdata_o,
  input wire logic         fl_rd_o,
  input wire logic [16:0]  fl_addr_o,
  input wire logic [127:0] fl_rdata_i
);
  logic [3:0]  ws_ff;
  logic [4:0]  nvm_ff;
  logic        ins_ff;
  logic        prd_ff;
  logic [16:0] tphr_ff;
  logic [16:0] padr_ff;
  logic [3:0]  run_ff;
  logic [3:0]  idx;
  logic        spec_ok;

  // Position of this cycle inside the current flash access.
  always_comb idx = (fl_rd_o && prd_ff && fl_addr_o == padr_ff) ? run_ff + 4'h1 : 4'h0;
  // Speculation gate as the control word leaves it for the taken request.
  always_comb spec_ok = !nvm_ff[2] && (ins_ff ? !nvm_ff[1] && !nvm_ff[3] : !nvm_ff[0]);

  // Mirrors settings written over the bus; the bench never writes the wait code mid-access.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ws_ff <= 4'h3;
      nvm_ff <= 5'h04;
      ins_ff <= 1'b0;
      tphr_ff <= 17'h0;
      prd_ff <= 1'b0;
      padr_ff <= 17'h0;
      run_ff <= 4'h0;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == 8'h00) ws_ff <= reg_wdata_i[3:0];
      if (reg_wr_i && reg_addr_i == 8'h04) nvm_ff <= reg_wdata_i[4:0];
      if (req_i && ready_o) ins_ff <= req_instr_i;
      if (req_i && ready_o) tphr_ff <= req_addr_i[20:4];
      prd_ff <= fl_rd_o;
      padr_ff <= fl_addr_o;
      run_ff <= idx;
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  AST_WS_LEN: assert property (fl_rd_o |-> idx <= ws_ff)
    else $error("flash access longer than wait code");
  AST_WS_HOLD: assert property (fl_rd_o && idx < ws_ff |=> fl_rd_o && $stable(fl_addr_o))
    else $error("flash access cut short");
  AST_HIT_FAST: assert property (req_i && ready_o ##1 !fl_rd_o |-> ##[0:1] ack_o)
    else $error("hit answered late");
  AST_SPEC_NEXT: assert property ($past(fl_rd_o) && ack_o && spec_ok |->
    fl_rd_o && fl_addr_o == $past(fl_addr_o) + 17'h1)
    else $error("no fetch of next phrase");
  AST_SPEC_BLOCK: assert property ($past(fl_rd_o) && ack_o && !spec_ok |-> !fl_rd_o)
    else $error("speculation while blocked");
  AST_PF_NEXT: assert property (req_i && ready_o ##1 (ack_o && spec_ok) |->
    ##[0:1] (fl_rd_o && fl_addr_o == tphr_ff + 17'h1))
    else $error("buffer hit did not fetch ahead");
  AST_OFF_REFETCH: assert property (req_i && ready_o && nvm_ff[4] ##1 !ack_o |-> fl_rd_o)
    else $error("cache off but no flash read");
  AST_REG_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule : fra_flash_read_accel_checker

bind fra_flash_read_accel fra_flash_read_accel_checker i_chk (.*);
`default_nettype wire

// *** testbench/fra_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fra_flash_model (
  input  wire logic         mclk_i,
  input  wire logic         fl_rd_i,
  input  wire logic [16:0]  fl_addr_i,
  output logic      [127:0] fl_data_o
);
  logic tgl_ff = 1'b0;

  // Idle lines churn so a stale sample never looks like good data.
  always @(posedge mclk_i) tgl_ff <= !tgl_ff;

  // Each word carries its phrase and index, so a wrong pick shows at once.
  always_comb
  begin
    for (int w = 0; w < 4; w++)
      fl_data_o[w*32 +: 32] = fl_rd_i ? {fl_addr_i, 13'h1B3D, 2'(w)} : {32{tgl_ff}} ^ 32'hA5A5_5A5A;
  end
endmodule : fra_flash_model
`default_nettype wire

// *** testbench/fra_flash_read_accel_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module fra_flash_read_accel_bench;
  logic         mclk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  logic [7:0]   reg_addr_i = 8'h00;
  logic [31:0]  reg_wdata_i = 32'h0;
  logic         reg_wr_i = 1'b0;
  logic         reg_rd_i = 1'b0;
  logic         req_i = 1'b0;
  logic         req_instr_i = 1'b0;
  logic [20:0]  req_addr_i = 21'h0;
  logic [31:0]  reg_rdata_o;
  logic [31:0]  rdata_o;
  logic         ready_o;
  logic         ack_o;
  logic         fl_rd_o;
  logic [16:0]  fl_addr_o;
  logic [127:0] fl_rdata_i;
  int           err_total = 0;
  int           n_compared = 0;

  fra_flash_read_accel i_dut (.*);
  fra_flash_model i_fl (.mclk_i(mclk_i), .fl_rd_i(fl_rd_o), .fl_addr_i(fl_addr_o),
                        .fl_data_o(fl_rdata_i));

  // Free-running 50 MHz clock.
  initial
  begin
    forever #10 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] ew(input logic [20:0] a);
    ew = {a[20:4], 13'h1B3D, a[3:2]};
  endfunction : ew

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, e);
  endtask : rd

  // Bounded wait until the engine accepts requests again.
  task automatic idle;
    int n;
    n = 0;
    #1;
    while (ready_o !== 1'b1 && n < 50)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
  endtask : idle

  // Edges from take to answer: 0 buffer hit, 1 cache hit, W+1 miss.
  task automatic rq(input logic [20:0] a, input logic ins, input int lat);
    int n;
    idle();
    @(posedge mclk_i);
    req_i <= 1'b1;
    req_addr_i <= a;
    req_instr_i <= ins;
    @(posedge mclk_i);
    req_i <= 1'b0;
    n = 0;
    #1;
    while (ack_o !== 1'b1 && n < 40)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    check(rdata_o, ew(a));
    if (lat >= 0) check(32'(n), 32'(lat));
  endtask : rq

  // Main sequence; misses run at wait code 3 from the end of the first loop until the random requests, which run at code 1.
  initial
  begin
    void'($urandom(32'h67e0));
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(8'h00, 32'h3);
    rd(8'h04, 32'h4);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    for (int w = 0; w < 4; w++)
    begin
      wr(8'h00, 32'(w));
      rd(8'h00, 32'(w));
      rq({17'(32'h100 + w), 4'h0}, 1'b0, w + 1);
      rq({17'(32'h100 + w), 4'h4}, 1'b1, 1);
    end
    wr(8'h08, 32'hF0);
    rd(8'h0C, 32'h0);
    for (int p = 0; p < 4; p++) rq({17'(32'h200 + p), 4'h0}, 1'b0, 4);
    rq({17'h00200, 4'h8}, 1'b0, 1);
    rq({17'h00204, 4'h0}, 1'b0, 4);
    rq({17'h00200, 4'h0}, 1'b0, 1);
    rq({17'h00201, 4'h0}, 1'b0, 4);
    rd(8'h0C, 32'hF);
    wr(8'h08, 32'hFF);
    rq({17'h00300, 4'h0}, 1'b0, 4);
    rq({17'h00300, 4'h4}, 1'b0, 4);
    rd(8'h0C, 32'h0);
    wr(8'h08, 32'h20F);
    rd(8'h08, 32'h20F);
    wr(8'h08, 32'h200);
    for (int p = 0; p < 4; p++) rq({17'(32'h600 + p), 4'h0}, 1'b0, 4);
    rq({17'h00600, 4'h4}, 1'b0, 1);
    rq({17'h00604, 4'h0}, 1'b0, 4);
    rq({17'h00600, 4'h0}, 1'b0, 4);
    wr(8'h08, 32'hF0);
    wr(8'h04, 32'h0);
    rq({17'h00400, 4'h0}, 1'b0, 4);
    rq({17'h00401, 4'h0}, 1'b0, 0);
    idle();
    rd(8'h0C, 32'h13);
    wr(8'h08, 32'h100);
    rd(8'h0C, 32'h03);
    rq({17'h00402, 4'h0}, 1'b0, 4);
    wr(8'h04, 32'h10);
    rq({17'h00500, 4'h0}, 1'b1, 4);
    rq({17'h00501, 4'h0}, 1'b1, 0);
    rq({17'h00500, 4'h4}, 1'b1, 4);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h1);
    repeat (40) rq({13'h0, 4'($urandom), 2'($urandom), 2'h0}, 1'($urandom), -1);
    stop_test();
  end

  // Cuts a hang short well past the expected run of under a thousand cycles.
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    stop_test();
  end
endmodule : fra_flash_read_accel_bench
`default_nettype wire
